// File: rtl/pdc_bank.sv
// configuration bank for pll, dll, vco, offsets and data-out routing
//
// Chosen here: register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "pdc_regs.svh"
module pdc_bank (
	input  wire logic  clk,
	input  wire logic  sys_rst,
	pdc_link_if.dev    lnk,
	input  wire logic  pll_locked_flag,
	input  wire logic  dll_locked_flag,
	input  wire logic  pattern_fault,
	input  wire logic  fifo_fault,
	input  wire logic  selftest_fault,
	output logic [4:0] pll_feedback_mult,
	output logic [2:0] pll_ref_div,
	output logic [3:0] dll_phase_trim,
	output logic       dll_clock_invert,
	output logic [2:0] dll_bias_select,
	output logic       loop_filter_clear,
	output logic       pll_restart,
	output logic       vco_half_output,
	output logic [3:0] vco_bias_range,
	output logic [1:0] vco_gain,
	output logic [12:0] chan_a_work,
	output logic [12:0] chan_b_work,
	input  wire logic [12:0] chan_b_offset
);
	logic [7:0] div_ff, dll_ff, vco_ff, hi_ff, lo_ff, sdo_ff, rsv_ff;
	logic [7:0] rdata_ff;
	logic       sdo_ff_out;
	logic       strobe_q_ff;
	logic       clear_q_ff;
	logic       restart_ff;
	logic [12:0] wa_ff, wb_ff;
	logic [12:0] chan_a_offset;
	logic       status_bit;
	logic       status_sel;
	pdc_pkg::pdc_src_t src;
	logic       we_div, we_dll, we_vco, we_hi, we_lo, we_sdo, we_rsv;
	logic       strobe_rise;
	logic       clear_fall;

	// one write enable per bank word; low addresses match none
	assign we_div = lnk.wr_en && lnk.addr == `PDC_ADDR_DIV;
	assign we_dll = lnk.wr_en && lnk.addr == `PDC_ADDR_DLL;
	assign we_vco = lnk.wr_en && lnk.addr == `PDC_ADDR_VCO;
	assign we_hi  = lnk.wr_en && lnk.addr == `PDC_ADDR_OFS_HI;
	assign we_lo  = lnk.wr_en && lnk.addr == `PDC_ADDR_OFS_LO;
	assign we_sdo = lnk.wr_en && lnk.addr == `PDC_ADDR_SDO;
	assign we_rsv = lnk.wr_en && lnk.addr == `PDC_ADDR_RSVD;

	// pll divider word; invalid codes are kept, never corrected
	always_ff @(posedge clk) begin
		if (sys_rst)
			div_ff <= `PDC_RST_VAL; // R18
		else if (we_div)
			div_ff <= lnk.wdata; // R1 R2
	end

	// dll delay word; trim, inversion and bias as written
	always_ff @(posedge clk) begin
		if (sys_rst)
			dll_ff <= `PDC_RST_VAL;
		else if (we_dll)
			dll_ff <= lnk.wdata; // R4 R5 R6
	end

	// vco loop word; clear, halving, gain and range
	always_ff @(posedge clk) begin
		if (sys_rst)
			vco_ff <= `PDC_RST_VAL;
		else if (we_vco)
			vco_ff <= lnk.wdata; // R7 R8 R9
	end

	// offset high bits and load strobe; strobe only cleared by host
	always_ff @(posedge clk) begin
		if (sys_rst)
			hi_ff <= `PDC_RST_VAL;
		else if (we_hi)
			hi_ff <= lnk.wdata; // R11
	end

	// offset low byte, held until the next write to 0x0d
	always_ff @(posedge clk) begin
		if (sys_rst)
			lo_ff <= `PDC_RST_VAL;
		else if (we_lo)
			lo_ff <= lnk.wdata; // R13
	end

	// data-out source word
	always_ff @(posedge clk) begin
		if (sys_rst)
			sdo_ff <= `PDC_RST_VAL;
		else if (we_sdo)
			sdo_ff <= lnk.wdata; // R14
	end

	// reserved word; stored so a read shows what was sent
	always_ff @(posedge clk) begin
		if (sys_rst)
			rsv_ff <= `PDC_RST_VAL;
		else if (we_rsv)
			rsv_ff <= lnk.wdata; // R18
	end

	// read back last written value; registers below 0x09 read zero
	always_ff @(posedge clk) begin
		if (sys_rst)
			rdata_ff <= `PDC_RST_VAL;
		else if (lnk.rd_en) begin
			unique case (lnk.addr)
				`PDC_ADDR_DIV:    rdata_ff <= div_ff; // R18
				`PDC_ADDR_DLL:    rdata_ff <= dll_ff;
				`PDC_ADDR_VCO:    rdata_ff <= vco_ff;
				`PDC_ADDR_OFS_HI: rdata_ff <= hi_ff;
				`PDC_ADDR_OFS_LO: rdata_ff <= lo_ff;
				`PDC_ADDR_SDO:    rdata_ff <= sdo_ff;
				`PDC_ADDR_RSVD:   rdata_ff <= rsv_ff;
				default:          rdata_ff <= `PDC_RST_VAL;
			endcase
		end
	end

	assign chan_a_offset = {hi_ff[`PDC_OFS_HI_MSB:0], lo_ff}; // R13

	// strobe edge; a level would reload on every offset write
	assign strobe_rise = hi_ff[`PDC_STROBE_BIT] && !strobe_q_ff;

	// previous strobe level, for the rising edge only
	always_ff @(posedge clk) begin
		if (sys_rst)
			strobe_q_ff <= 1'b0;
		else
			strobe_q_ff <= hi_ff[`PDC_STROBE_BIT];
	end

	// double buffer: working offsets move only on a strobe rise
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wa_ff <= 13'h0000;
			wb_ff <= 13'h0000;
		end else if (strobe_rise) begin
			wa_ff <= chan_a_offset; // R10
			wb_ff <= chan_b_offset; // R10
		end
	end

	// falling clear; while high the loop filter stays grounded
	assign clear_fall = clear_q_ff && !vco_ff[`PDC_CLEAR_BIT];

	// previous clear level
	always_ff @(posedge clk) begin
		if (sys_rst)
			clear_q_ff <= 1'b0;
		else
			clear_q_ff <= vco_ff[`PDC_CLEAR_BIT];
	end

	// one-cycle restart pulse; a level would restart the loop twice
	always_ff @(posedge clk) begin
		if (sys_rst)
			restart_ff <= 1'b0;
		else
			restart_ff <= clear_fall; // R7
	end

	// data-out routing; status select overrides read data in both serial modes
	always_comb begin
		src = pdc_pkg::pdc_src_t'(sdo_ff[`PDC_SDO_MSB:`PDC_SDO_LSB]);
		status_sel = 1'b1;
		unique case (src)
			pdc_pkg::PDC_SRC_PLL_LOCK: status_bit = pll_locked_flag; // R14
			pdc_pkg::PDC_SRC_DLL_LOCK: status_bit = dll_locked_flag;
			pdc_pkg::PDC_SRC_PATTERN:  status_bit = pattern_fault;
			pdc_pkg::PDC_SRC_FIFO:     status_bit = fifo_fault;
			pdc_pkg::PDC_SRC_SELFTEST: status_bit = selftest_fault;
			default: begin
				status_bit = 1'b0;
				status_sel = 1'b0;
			end
		endcase
	end

	// serial read data is the msb of the read word in this model
	always_ff @(posedge clk) begin
		if (sys_rst)
			sdo_ff_out <= 1'b0;
		else if (status_sel)
			sdo_ff_out <= status_bit; // R15 R17
		else
			sdo_ff_out <= rdata_ff[`PDC_SER_BIT];
	end

	// link side: registered read word and data-out level
	assign lnk.rdata         = rdata_ff;
	assign lnk.sdo_out       = sdo_ff_out;

	// pll divider and dll fields, straight from the stored words
	assign pll_feedback_mult = div_ff[`PDC_MULT_MSB:`PDC_MULT_LSB]; // R1
	assign pll_ref_div       = div_ff[`PDC_DIV_MSB:0]; // R2
	assign dll_phase_trim    = dll_ff[`PDC_TRIM_MSB:`PDC_TRIM_LSB]; // R4
	assign dll_clock_invert  = dll_ff[`PDC_INV_BIT]; // R5
	assign dll_bias_select   = dll_ff[`PDC_BIAS_MSB:0]; // R6

	// vco loop fields; gain is passed on untouched
	assign loop_filter_clear = vco_ff[`PDC_CLEAR_BIT]; // R7
	assign pll_restart       = restart_ff;
	assign vco_half_output   = vco_ff[`PDC_HALF_BIT]; // R8
	assign vco_gain          = vco_ff[`PDC_GAIN_MSB:`PDC_GAIN_LSB];
	assign vco_bias_range    = vco_ff[`PDC_RANGE_MSB:0]; // R9

	// working offsets feed the offset datapaths
	assign chan_a_work       = wa_ff;
	assign chan_b_work       = wb_ff;
endmodule : pdc_bank
`default_nettype wire

// File: rtl/pdc_regs.svh
// register map, field positions and command codes for the pll/dll bank
// Contract
// [R1] feedback multiplier field is thermometer 1..32
// [R2] reference divider field is thermometer 1..8
// [R3] host keeps phase detector at most 160 MHz
// [R4] phase trim signed 5-degree steps around 90
// [R5] clock invert bit inverts internal dll clock
// [R6] bias select levels; host never writes 100
// [R7] loop filter clear holds filter; fall restarts
// [R8] half output bit halves vco output clock
// [R9] vco bias range 000 lowest, 111 highest
// [R10] strobe rise copies offsets to working registers
// [R11] strobe bit never self-clears
// [R12] host clears strobe before new offsets
// [R13] chan a offset from 0x0c[4:0] and 0x0d
// [R14] source select code routes data-out pin
// [R15] four-wire status select overrides read data
// [R16] host writes zero to reserved fields
// [R17] mode bit chooses four or three wire; the bank ignores four_wire_select
// [R18] registers reset zero, read back, no fixups
`ifndef PDC_REGS_SVH
`define PDC_REGS_SVH
`define PDC_ADDR_DIV      4'h9
`define PDC_ADDR_DLL      4'ha
`define PDC_ADDR_VCO      4'hb
`define PDC_ADDR_OFS_HI   4'hc
`define PDC_ADDR_OFS_LO   4'hd
`define PDC_ADDR_SDO      4'he
`define PDC_ADDR_RSVD     4'hf
`define PDC_RST_VAL       8'h00
`define PDC_STROBE_BIT    5
`define PDC_OFS_HI_MSB    4
`define PDC_CLEAR_BIT     7
`define PDC_HALF_BIT      6
`define PDC_SDO_LSB       5
`define PDC_HI_RSVD       8'hc0
`define PDC_SDO_RSVD      8'h1f
// field positions inside the bank words
`define PDC_MULT_MSB      7
`define PDC_MULT_LSB      3
`define PDC_DIV_MSB       2
`define PDC_TRIM_MSB      7
`define PDC_TRIM_LSB      4
`define PDC_INV_BIT       3
`define PDC_BIAS_MSB      2
`define PDC_GAIN_MSB      5
`define PDC_GAIN_LSB      4
`define PDC_RANGE_MSB     3
`define PDC_SDO_MSB       7
`define PDC_SER_BIT       7
// field positions inside the controller's own words
`define PDC_CMD_RD_BIT    8
`define PDC_CMD_ADDR_MSB  3
`define PDC_MODE_BIT      0
`define PDC_MASK_MSB      1
// apb word offsets of the controller's own registers
`define PDC_APB_CMD       12'h000
`define PDC_APB_DATA      12'h004
`define PDC_APB_STAT      12'h008
`define PDC_APB_MASK      12'h00c
`define PDC_APB_MODE      12'h010
`define PDC_APB_RDAT      12'h014
`endif

// File: rtl/pdc_pkg.sv
// types used by the configuration bank end of the link
package pdc_pkg;
	typedef enum logic [2:0] {
		PDC_SRC_NORMAL,
		PDC_SRC_PLL_LOCK,
		PDC_SRC_DLL_LOCK,
		PDC_SRC_PATTERN,
		PDC_SRC_FIFO,
		PDC_SRC_SELFTEST,
		PDC_SRC_NORM6,
		PDC_SRC_NORM7
	} pdc_src_t;
endpackage : pdc_pkg

// File: rtl/pdc_link_if.sv
// register-port link between controller and configuration bank
`timescale 1ns/100ps
`default_nettype none
interface pdc_link_if;
	logic       wr_en;
	logic       rd_en;
	logic [3:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic       sdo_out;
	logic       four_wire_select;
	modport dev (input wr_en, rd_en, addr, wdata, four_wire_select,
		output rdata, sdo_out);
	modport host (output wr_en, rd_en, addr, wdata, four_wire_select,
		input rdata, sdo_out);
endinterface : pdc_link_if
`default_nettype wire

// File: rtl/pdc_host.sv
// apb-driven controller that writes and reads the configuration bank
`timescale 1ns/100ps
`default_nettype none
`include "pdc_regs.svh"
module pdc_host (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	pdc_link_if.host         lnk,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             irq
);
	logic [31:0] prdata_ff;
	logic        pready_ff, pslverr_ff, irq_ff;
	logic        wr_ff, rd_ff, mode_ff, cap_ff;
	logic [3:0]  addr_ff;
	logic [7:0]  wdata_ff, rdat_ff, data_ff;
	logic [1:0]  stat_ff, mask_ff;
	logic        acc, stat_rd, bad_addr, cmd_wr, done_ev, sdo_q_ff, sdo_ev;

	assign acc      = psel && penable && !pready_ff;
	assign cmd_wr   = acc && pwrite && paddr == `PDC_APB_CMD;
	assign stat_rd  = acc && !pwrite && paddr == `PDC_APB_STAT;
	assign bad_addr = !(paddr == `PDC_APB_CMD || paddr == `PDC_APB_DATA ||
		paddr == `PDC_APB_STAT || paddr == `PDC_APB_MASK ||
		paddr == `PDC_APB_MODE || paddr == `PDC_APB_RDAT);
	assign done_ev  = cap_ff;
	assign sdo_ev   = lnk.sdo_out && !sdo_q_ff;

	// apb: one wait state, answer on the cycle after access starts
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h0000_0000;
		end else begin
			pready_ff  <= acc;
			pslverr_ff <= acc && bad_addr;
			if (acc && !pwrite) begin
				unique case (paddr)
					`PDC_APB_DATA: prdata_ff <= {24'h000000, data_ff};
					`PDC_APB_STAT: prdata_ff <= {30'h0, stat_ff};
					`PDC_APB_MASK: prdata_ff <= {30'h0, mask_ff};
					`PDC_APB_MODE: prdata_ff <= {31'h0, mode_ff};
					`PDC_APB_RDAT: prdata_ff <= {24'h000000, rdat_ff};
					default:       prdata_ff <= 32'h0000_0000;
				endcase
			end
		end
	end

	// software-owned settings; mode drives four_wire_select, which the bank leaves unused
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			data_ff <= 8'h00;
			mask_ff <= 2'h0;
			mode_ff <= 1'b0;
		end else if (acc && pwrite) begin
			if (paddr == `PDC_APB_DATA) data_ff <= pwdata[7:0];
			if (paddr == `PDC_APB_MASK)
				mask_ff <= pwdata[`PDC_MASK_MSB:0];
			if (paddr == `PDC_APB_MODE)
				mode_ff <= pwdata[`PDC_MODE_BIT]; // R17
		end
	end

	// cmd word: bit 8 read, else write; bits 3:0 bank address
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wr_ff    <= 1'b0;
			rd_ff    <= 1'b0;
			addr_ff  <= 4'h0;
			wdata_ff <= 8'h00;
			cap_ff   <= 1'b0;
		end else begin
			wr_ff  <= cmd_wr && !pwdata[`PDC_CMD_RD_BIT];
			rd_ff  <= cmd_wr && pwdata[`PDC_CMD_RD_BIT];
			cap_ff <= rd_ff;
			if (cmd_wr) begin
				addr_ff <= pwdata[`PDC_CMD_ADDR_MSB:0];
				// reserved fields forced to zero on the way out R16
				unique case (pwdata[`PDC_CMD_ADDR_MSB:0])
					`PDC_ADDR_OFS_HI: wdata_ff <= data_ff & ~`PDC_HI_RSVD;
					`PDC_ADDR_SDO:    wdata_ff <= data_ff & ~`PDC_SDO_RSVD;
					`PDC_ADDR_RSVD:   wdata_ff <= `PDC_RST_VAL;
					default:          wdata_ff <= data_ff;
				endcase
			end
		end
	end

	// read word is valid one cycle after the read strobe
	always_ff @(posedge clk) begin
		if (sys_rst)
			rdat_ff <= 8'h00;
		else if (cap_ff)
			rdat_ff <= lnk.rdata;
	end

	// sticky events, set wins over read clear
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			stat_ff  <= 2'h0;
			sdo_q_ff <= 1'b0;
			irq_ff   <= 1'b0;
		end else begin
			sdo_q_ff   <= lnk.sdo_out;
			stat_ff[0] <= done_ev || (stat_ff[0] && !stat_rd);
			stat_ff[1] <= sdo_ev || (stat_ff[1] && !stat_rd);
			irq_ff     <= |(stat_ff & mask_ff);
		end
	end

	assign lnk.wr_en            = wr_ff;
	assign lnk.rd_en            = rd_ff;
	assign lnk.addr             = addr_ff;
	assign lnk.wdata            = wdata_ff;
	assign lnk.four_wire_select = mode_ff;
	assign prdata               = prdata_ff;
	assign pready               = pready_ff;
	assign pslverr              = pslverr_ff;
	assign irq                  = irq_ff;
endmodule : pdc_host
`default_nettype wire

// File: verif/pdc_link_chk.sv
// assertions on the link between controller and configuration bank
`timescale 1ns/100ps
`default_nettype none
module pdc_link_chk (
	input wire logic       clk,
	input wire logic       sys_rst,
	input wire logic       wr_en,
	input wire logic       rd_en,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic       sdo_out,
	input wire logic       four_wire_select
);
	logic [7:0] shadow_ff [16];
	logic       norm;
	// copy of every write, so reads can be judged against it
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			for (int i = 0; i < 16; i++) shadow_ff[i] <= 8'h00;
		end else if (wr_en) begin
			shadow_ff[addr] <= wdata;
		end
	end
	// selection codes that leave the pin on serial data
	assign norm = shadow_ff[14][7:5] == 3'h0 || shadow_ff[14][7:6] == 2'h3;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_write_strobe_pulse: assert property (wr_en |=> !wr_en)
		else $error("write strobe longer than one cycle");
	a_no_dual_strobe: assert property (!(wr_en && rd_en))
		else $error("read and write strobes together");
	a_hi_rsvd_zero: assert property (
		wr_en && addr == 4'hc |-> wdata[7:6] == 2'h0)
		else $error("reserved offset bits written nonzero");
	a_sel_rsvd_zero: assert property (
		wr_en && addr == 4'he |-> wdata[4:0] == 5'h00)
		else $error("reserved select bits written nonzero");
	a_rsvd_reg_zero: assert property (
		wr_en && addr == 4'hf |-> wdata == 8'h00)
		else $error("reserved register written nonzero");
	a_low_addr_zero: assert property (
		rd_en && addr < 4'h9 |=> rdata == 8'h00)
		else $error("unmapped bank address read nonzero");
	a_rdata_holds: assert property (!rd_en |=> $stable(rdata))
		else $error("read data moved without a read");
	a_read_back: assert property (
		rd_en && addr >= 4'h9 |=> rdata == $past(shadow_ff[addr]))
		else $error("bank read differs from last write");
	a_sdo_normal: assert property (
		norm && $past(norm) |-> sdo_out == $past(rdata[7]))
		else $error("data-out pin not on serial data");
endmodule : pdc_link_chk
`default_nettype wire

// File: verif/pll_dll_offset_config_bench.sv
// self-checking bench: apb controller driving the configuration bank
`timescale 1ns/100ps
`default_nettype none
`include "pdc_regs.svh"
module pll_dll_offset_config_bench;
	logic        clk, sys_rst, psel, penable, pwrite, pready, pslverr, irq;
	logic        e, inv, lfc, rst_p, half;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [4:0]  fl, fbm;
	logic [2:0]  rdv, bias;
	logic [3:0]  trim, vbr, a4;
	logic [1:0]  gain;
	logic [12:0] aw, bw, bofs;
	logic [7:0]  v, t;
	int          seed, n_errors, samples_checked, cyc, n_rst;
	pdc_link_if pdc_link_if_inst ();
	pdc_bank pdc_bank_inst (.clk, .sys_rst, .lnk(pdc_link_if_inst),
		.pll_locked_flag(fl[0]), .dll_locked_flag(fl[1]),
		.pattern_fault(fl[2]), .fifo_fault(fl[3]), .selftest_fault(fl[4]),
		.pll_feedback_mult(fbm), .pll_ref_div(rdv), .dll_phase_trim(trim),
		.dll_clock_invert(inv), .dll_bias_select(bias),
		.loop_filter_clear(lfc), .pll_restart(rst_p), .vco_half_output(half),
		.vco_bias_range(vbr), .vco_gain(gain), .chan_a_work(aw),
		.chan_b_work(bw), .chan_b_offset(bofs));
	pdc_host pdc_host_inst (.clk, .sys_rst, .lnk(pdc_link_if_inst), .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq);
	pdc_link_chk pdc_link_chk_inst (.clk, .sys_rst,
		.wr_en(pdc_link_if_inst.wr_en), .rd_en(pdc_link_if_inst.rd_en),
		.addr(pdc_link_if_inst.addr), .wdata(pdc_link_if_inst.wdata),
		.rdata(pdc_link_if_inst.rdata), .sdo_out(pdc_link_if_inst.sdo_out),
		.four_wire_select(pdc_link_if_inst.four_wire_select));
	// one apb transfer; request held until pready is seen
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// no local limit: only the bench timeout ends a wait
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	// bank write, with time for the edge detect to land
	task lw(input logic [3:0] a, input logic [7:0] d);
		apb(1'b1, `PDC_APB_DATA, {24'h0, d});
		apb(1'b1, `PDC_APB_CMD, {28'h0, a});
		repeat (4) @(posedge clk);
	endtask : lw
	// bank read: command, poll done flag, fetch word
	task lr(input logic [3:0] a);
		apb(1'b1, `PDC_APB_CMD, 32'h100 + 32'(a));
		r = 32'h0;
		for (int i = 0; i < 20 && r[0] !== 1'b1; i++)
			apb(1'b0, `PDC_APB_STAT, 32'h0);
		apb(1'b0, `PDC_APB_RDAT, 32'h0);
	endtask : lr
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// read-back after the host clears reserved bits
	function automatic logic [7:0] kept(input logic [3:0] a,
		input logic [7:0] d);
		case (a)
			4'hc: kept = d & 8'h3f;
			4'he: kept = d & 8'he0;
			4'hf: kept = 8'h00;
			default: kept = d;
		endcase
	endfunction : kept
	task results;
		if (n_errors == 0 && samples_checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : results
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// hang guard, far above the expected run length
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			n_errors++;
			results();
		end
	end
	always @(posedge clk) if (rst_p === 1'b1) n_rst++;
	initial begin
		seed = 32'h75d098cb;
		{psel, penable, pwrite, paddr, pwdata, fl, bofs} = '0;
		sys_rst = 1'b1;
		repeat (4) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		for (int a = 9; a < 16; a++) begin
			lr(4'(a));
			chk(r, 32'h0);
		end
		// offsets: no copy until the strobe rises
		bofs <= 13'($random(seed));
		lw(4'hd, 8'ha5);
		lw(4'hc, 8'h13);
		chk(aw, 32'h0);
		lw(4'hc, 8'h33);
		chk(aw, 32'h13a5);
		chk(bw, bofs);
		lr(4'hc);
		chk(r, 32'h33);
		lw(4'hd, 8'h5a);
		bofs <= 13'($random(seed));
		chk(aw, 32'h13a5);
		lw(4'hc, 8'h0e);
		lw(4'hc, 8'h2e);
		chk(aw, 32'h0e5a);
		chk(bw, bofs);
		// loop filter hold and one restart on release
		lw(4'hb, 8'h80);
		chk(lfc, 32'h1);
		n_rst = 0;
		lw(4'hb, 8'h00);
		chk(n_rst, 32'h1);
		for (int i = 0; i < 6; i++) begin
			v = ~(8'hff << i);
			t = ~(8'hff << (i % 4));
			lw(4'h9, {v[4:0], t[2:0]});
			chk({fbm, rdv}, {v[4:0], t[2:0]});
		end
		for (int i = 0; i < 14; i++) begin
			v = 8'($random(seed));
			a4 = 4'(9 + i % 7);
			if (a4 == 4'ha && v[2:0] == 3'h4) v[2:0] = 3'h0;
			lw(a4, v);
			lr(a4);
			chk(r, kept(a4, v));
			if (a4 == 4'h9) chk({fbm, rdv}, v);
			if (a4 == 4'ha) chk({trim, inv, bias}, v);
			if (a4 == 4'hb) chk({lfc, half, gain, vbr}, v);
		end
		// every source code in both serial modes
		for (int m = 0; m < 2; m++) begin
			apb(1'b1, `PDC_APB_MODE, 32'(m));
			chk(pdc_link_if_inst.four_wire_select, 32'(m));
			for (int c = 0; c < 8; c++) begin
				fl <= 5'($random(seed));
				lw(4'he, 8'(c << 5));
				lr(4'he);
				chk(pdc_link_if_inst.sdo_out, (c > 0 && c < 6) ? fl[c-1] : c[2]);
			end
		end
		apb(1'b0, 12'h020, 32'h0);
		chk(e, 32'h1);
		chk(r, 32'h0);
		lw(4'h3, 8'h5a);
		lr(4'h3);
		chk(r, 32'h0);
		// interrupt raised, cleared by status read, then masked
		apb(1'b1, `PDC_APB_MASK, 32'h1);
		apb(1'b1, `PDC_APB_CMD, 32'h109);
		for (int i = 0; i < 20 && irq !== 1'b1; i++) @(posedge clk);
		chk(irq, 32'h1);
		apb(1'b0, `PDC_APB_STAT, 32'h0);
		chk(r[0], 32'h1);
		repeat (2) @(posedge clk);
		chk(irq, 32'h0);
		apb(1'b1, `PDC_APB_MASK, 32'h0);
		apb(1'b1, `PDC_APB_CMD, 32'h109);
		repeat (6) @(posedge clk);
		chk(irq, 32'h0);
		results();
	end
endmodule : pll_dll_offset_config_bench
`default_nettype wire
